// *** rtl/icror_pkg.sv ***
// ==========================================================================
// Shared constants and carriers for the clear / override register bank
// ==========================================================================
package icror_pkg;

    // ======================================================================
    // Register indices; byte address is four times the index
    // ======================================================================
    localparam int          ICROR_IDX_W         = 14;
    localparam logic [13:0] ICROR_IDX_DPLL_CLR  = 14'h0a06;
    localparam logic [13:0] ICROR_IDX_HIST_CLR  = 14'h0a07;
    localparam logic [13:0] ICROR_IDX_REFAB_CLR = 14'h0a08;
    localparam logic [13:0] ICROR_IDX_REFCD_CLR = 14'h0a09;
    localparam logic [13:0] ICROR_IDX_PHASE_CTL = 14'h0a0a;
    localparam logic [13:0] ICROR_IDX_VAL_FORCE = 14'h0a0b;
    localparam logic [13:0] ICROR_IDX_FAULT_OVR = 14'h0a0c;
    localparam logic [13:0] ICROR_IDX_MON_BYP   = 14'h0a0d;
    localparam logic [13:0] ICROR_IDX_STEP_LO   = 14'h0312;
    localparam logic [13:0] ICROR_IDX_STEP_HI   = 14'h0313;
    localparam logic [13:0] ICROR_IDX_ACC_LO    = 14'h0314;
    localparam logic [13:0] ICROR_IDX_ACC_HI    = 14'h0315;
    localparam logic [13:0] ICROR_IDX_STAT_BASE = 14'h0d04;
    localparam logic [13:0] ICROR_IDX_EN_BASE   = 14'h0e04;

    // ======================================================================
    // Field positions and valid-bit masks
    // ======================================================================
    localparam int          ICROR_PH_RESET_BIT  = 2;
    localparam int          ICROR_PH_DEC_BIT    = 1;
    localparam int          ICROR_PH_INC_BIT    = 0;
    localparam logic [7:0]  ICROR_DPLL_MASK     = 8'hff;
    localparam logic [7:0]  ICROR_HIST_MASK     = 8'h1f;
    localparam logic [7:0]  ICROR_REF_MASK      = 8'h77;
    localparam logic [31:0] ICROR_EVT_MASK      = 32'h7777_1fff;

    // ======================================================================
    // Reset values and bus answers
    // ======================================================================
    localparam logic [3:0]  ICROR_OVR_RST       = 4'h0;
    localparam logic [3:0]  ICROR_BYP_RST       = 4'h0;
    localparam logic [15:0] ICROR_STEP_RST      = 16'h0000;
    localparam logic [15:0] ICROR_ACC_RST       = 16'h0000;
    localparam logic [31:0] ICROR_EN_RST        = 32'h0000_0000;
    localparam logic [1:0]  ICROR_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  ICROR_RESP_SLVERR   = 2'h2;

    // ======================================================================
    // Event carrier, one byte per clear register
    // ======================================================================
    typedef struct packed {
        logic [7:0] ref_cd;
        logic [7:0] ref_ab;
        logic [7:0] hist;
        logic [7:0] dpll;
    } icror_evt_t;

    typedef struct packed {
        logic [31:0] status;
        logic        irq;
    } icror_bank_st_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        aw_got;
        logic        w_got;
        logic [13:0] wr_idx;
        logic [7:0]  wbyte;
        logic        wlane;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [31:0] clr;
        logic [31:0] enable;
        logic [15:0] step;
        logic [15:0] phase_offset;
        logic [3:0]  force_valid;
        logic [3:0]  fault_ovr;
        logic [3:0]  mon_byp;
    } icror_top_st_t;

endpackage

// *** rtl/icror_evt_bank.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Sticky interrupt monitor flags with enable gating
// ==========================================================================
module icror_evt_bank import icror_pkg::*; (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire icror_evt_t  evt_set,
    input  wire logic [31:0] evt_clr,
    input  wire logic [31:0] evt_enable,
    output logic      [31:0] evt_status,
    output logic             irq
);

    icror_bank_st_t s_q;
    icror_bank_st_t s_d;
    logic [31:0]    st_next;

    // ======================================================================
    // Per-flag next value
    // ======================================================================
    for (genvar i = 0; i < 32; i++) begin : g_flag
        // set wins
        // Set beats a same-cycle clear so no event is ever lost
        assign st_next[i] = ((s_q.status[i] & ~evt_clr[i]) | evt_set[i]) & ICROR_EVT_MASK[i];
    end

    // Irq follows next status so it lines up with the flags
    always_comb begin
        s_d        = s_q;
        s_d.status = st_next;
        s_d.irq    = |(st_next & evt_enable);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign evt_status = s_q.status;
    assign irq        = s_q.irq;

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    flag_clear_a: assert property (evt_clr[0] && !evt_set[0] |=> !evt_status[0])
        else $error("flag survived its clear");
    set_wins_a: assert property (evt_set[3] && evt_clr[3] |=> evt_status[3])
        else $error("same-cycle event lost to clear");
    // Irq is registered, so an enable change shows one cycle later
    irq_level_a: assert property (irq == |(evt_status & $past(evt_enable)))
        else $error("irq disagrees with enabled flags");
    irq_rise_c: cover property (!irq ##1 irq);

endmodule // icror_evt_bank

// *** rtl/icror_top.sv ***
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - Index 0xa06 bits 7..0 clear the eight digital PLL event flags.
// - Index 0xa07 bit 4 clears history-updated flag; bits 7..5 reserved.
// - Index 0xa07 bits 3 and 2 clear frequency unclamped and clamped flags.
// - Index 0xa07 bits 1 and 0 clear phase slew unlimited and limited flags.
// - Index 0xa08 clears reference A and B events; bits 7, 3 reserved.
// - Index 0xa09 clears reference C and D events; bits 7, 3 reserved.
// - Index 0xa0a bit 2 zeroes the incremental phase offset.
// - Index 0xa0a bit 1 subtracts the programmed step from the offset.
// - Index 0xa0a bit 0 adds the programmed step to the offset.
// - Phase strobes self-clear, acting once per write; bit 2 overrides bits 1 and 0.
// - Index 0xa0b bit n forces reference n validation timer expiry, self-clearing.
// - Forced expiry lets the reference become valid at once.
// - Index 0xa0c bits 3..0 override each monitor fault output, reset 0.
// - Index 0xa0d bits 3..0 bypass each reference monitor, reset 0.
// - A written clear bit resets its monitor flag, dropping its request.
// - Clear bits self-clear after acting.
module icror_top import icror_pkg::*; #(
    parameter int ADDR_W = 16
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire icror_evt_t        evt_set,
    output logic [31:0]            evt_status,
    output logic                   irq,
    output logic [15:0]            phase_offset,
    output logic [3:0]             validation_force,
    output logic [3:0]             ref_fault_override,
    output logic [3:0]             ref_monitor_bypass
);

    localparam icror_top_st_t ICROR_TOP_RST = '{
        awready      : 1'b1,
        wready       : 1'b1,
        arready      : 1'b1,
        bresp        : ICROR_RESP_OKAY,
        rresp        : ICROR_RESP_OKAY,
        enable       : ICROR_EN_RST,
        step         : ICROR_STEP_RST,
        phase_offset : ICROR_ACC_RST,
        fault_ovr    : ICROR_OVR_RST,
        mon_byp      : ICROR_BYP_RST,
        default      : '0
    };

    icror_top_st_t      s_q;
    icror_top_st_t      s_d;
    logic               commit;
    logic [13:0]        rd_idx;
    logic [4:0]         lane_sh;
    logic [31:0]        status;

    // Write commits once address and data are both held
    assign commit  = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    assign rd_idx  = s_axi_araddr[ICROR_IDX_W+1:2];
    assign lane_sh = 5'({s_q.wr_idx[1:0], 3'b000});

    // ======================================================================
    // Sticky flags and interrupt
    // ======================================================================
    icror_evt_bank u_bank (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .evt_set    (evt_set),
        .evt_clr    (s_q.clr),
        .evt_enable (s_q.enable),
        .evt_status (status),
        .irq        (irq)
    );

    // ======================================================================
    // Next-state logic: bus slave, strobes and control bits
    // ======================================================================
    always_comb begin
        logic [4:0] rd_sh;
        rd_sh = 5'({rd_idx[1:0], 3'b000});
        s_d   = s_q;
        // one-shot strobes
        // Strobes live one cycle; nothing stores them, so no write-back needed
        s_d.force_valid = '0;
        s_d.clr = '0;

        // Write address channel
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_got  = 1'b1;
            s_d.awready = 1'b0;
            s_d.wr_idx  = s_axi_awaddr[ICROR_IDX_W+1:2];
        end
        // Write data channel; only lane 0 carries register bits
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_got  = 1'b1;
            s_d.wready = 1'b0;
            s_d.wbyte  = s_axi_wdata[7:0];
            s_d.wlane  = s_axi_wstrb[0];
        end

        if (commit) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = ICROR_RESP_OKAY;
            if (s_q.wr_idx[13:2] == ICROR_IDX_EN_BASE[13:2]) begin
                if (s_q.wlane) begin
                    s_d.enable[lane_sh +: 8] = s_q.wbyte & ICROR_EVT_MASK[lane_sh +: 8];
                end
            end else if (s_q.wr_idx[13:2] == ICROR_IDX_STAT_BASE[13:2]) begin
                // Status is read-only; writes are accepted and dropped
            end else begin
                case (s_q.wr_idx)
                    ICROR_IDX_DPLL_CLR: begin
                        if (s_q.wlane) s_d.clr[7:0] = s_q.wbyte & ICROR_DPLL_MASK;
                    end
                    // history, clamp and slew clears
                    // Reserved bits 7..5 are masked off here
                    ICROR_IDX_HIST_CLR: begin
                        if (s_q.wlane) s_d.clr[15:8] = s_q.wbyte & ICROR_HIST_MASK;
                    end
                    ICROR_IDX_REFAB_CLR: begin
                        if (s_q.wlane) s_d.clr[23:16] = s_q.wbyte & ICROR_REF_MASK;
                    end
                    ICROR_IDX_REFCD_CLR: begin
                        if (s_q.wlane) s_d.clr[31:24] = s_q.wbyte & ICROR_REF_MASK;
                    end
                    // reset beats step
                    // Inc and dec together cancel; reset wins over both
                    ICROR_IDX_PHASE_CTL: begin
                        if (s_q.wlane) begin
                            if (s_q.wbyte[ICROR_PH_RESET_BIT]) begin
                                s_d.phase_offset = '0;
                            end else begin
                                s_d.phase_offset = s_q.phase_offset
                                    + (s_q.wbyte[ICROR_PH_INC_BIT] ? s_q.step : 16'h0000)
                                    - (s_q.wbyte[ICROR_PH_DEC_BIT] ? s_q.step : 16'h0000);
                            end
                        end
                    end
                    ICROR_IDX_VAL_FORCE: begin
                        if (s_q.wlane) s_d.force_valid = s_q.wbyte[3:0];
                    end
                    ICROR_IDX_FAULT_OVR: begin
                        if (s_q.wlane) s_d.fault_ovr = s_q.wbyte[3:0];
                    end
                    ICROR_IDX_MON_BYP: begin
                        if (s_q.wlane) s_d.mon_byp = s_q.wbyte[3:0];
                    end
                    ICROR_IDX_STEP_LO: begin
                        if (s_q.wlane) s_d.step[7:0] = s_q.wbyte;
                    end
                    ICROR_IDX_STEP_HI: begin
                        if (s_q.wlane) s_d.step[15:8] = s_q.wbyte;
                    end
                    ICROR_IDX_ACC_LO, ICROR_IDX_ACC_HI: begin
                        // Accumulator moves only through the strobes
                    end
                    default: begin
                        s_d.bresp = ICROR_RESP_SLVERR;
                    end
                endcase
            end
        end

        // Response accepted: reopen both write channels
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end

        // Read channel: data answered at the edge that takes the address
        if (s_axi_arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rresp   = ICROR_RESP_OKAY;
            s_d.rdata   = '0;
            if (rd_idx[13:2] == ICROR_IDX_STAT_BASE[13:2]) begin
                s_d.rdata[7:0] = status[rd_sh +: 8];
            end else if (rd_idx[13:2] == ICROR_IDX_EN_BASE[13:2]) begin
                s_d.rdata[7:0] = s_q.enable[rd_sh +: 8];
            end else begin
                case (rd_idx)
                    ICROR_IDX_FAULT_OVR: s_d.rdata[3:0] = s_q.fault_ovr;
                    ICROR_IDX_MON_BYP:   s_d.rdata[3:0] = s_q.mon_byp;
                    ICROR_IDX_STEP_LO:   s_d.rdata[7:0] = s_q.step[7:0];
                    ICROR_IDX_STEP_HI:   s_d.rdata[7:0] = s_q.step[15:8];
                    ICROR_IDX_ACC_LO:    s_d.rdata[7:0] = s_q.phase_offset[7:0];
                    ICROR_IDX_ACC_HI:    s_d.rdata[7:0] = s_q.phase_offset[15:8];
                    // Write-only action registers read as zero
                    ICROR_IDX_DPLL_CLR, ICROR_IDX_HIST_CLR, ICROR_IDX_REFAB_CLR,
                    ICROR_IDX_REFCD_CLR, ICROR_IDX_PHASE_CTL,
                    ICROR_IDX_VAL_FORCE: s_d.rdata = '0;
                    default:             s_d.rresp = ICROR_RESP_SLVERR;
                endcase
            end
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= ICROR_TOP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // All outputs straight from state registers; evt_status and irq come from the bank's
    assign s_axi_awready      = s_q.awready;
    assign s_axi_wready       = s_q.wready;
    assign s_axi_bvalid       = s_q.bvalid;
    assign s_axi_bresp        = s_q.bresp;
    assign s_axi_arready      = s_q.arready;
    assign s_axi_rvalid       = s_q.rvalid;
    assign s_axi_rdata        = s_q.rdata;
    assign s_axi_rresp        = s_q.rresp;
    assign evt_status         = status;
    assign phase_offset       = s_q.phase_offset;
    assign validation_force   = s_q.force_valid;
    assign ref_fault_override = s_q.fault_ovr;
    assign ref_monitor_bypass = s_q.mon_byp;

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic wr_phase;
    assign wr_phase = commit && s_q.wlane && (s_q.wr_idx == ICROR_IDX_PHASE_CTL);

    dpll_clear_a: assert property (
        commit && s_q.wlane && s_q.wr_idx == ICROR_IDX_DPLL_CLR
        |=> s_q.clr[7:0] == $past(s_q.wbyte))
        else $error("pll clear byte not passed on");
    hist_clear_a: assert property (
        commit && s_q.wlane && s_q.wr_idx == ICROR_IDX_HIST_CLR
        |=> s_q.clr[15:8] == {3'h0, $past(s_q.wbyte[4:0])})
        else $error("history clear byte wrong");
    clamp_clear_a: assert property (
        commit && s_q.wlane && s_q.wr_idx == ICROR_IDX_HIST_CLR && s_q.wbyte[3]
        |=> s_q.clr[11] ##1 !s_q.clr[11])
        else $error("unclamped clear not a single pulse");
    slew_clear_a: assert property (
        commit && s_q.wlane && s_q.wr_idx == ICROR_IDX_HIST_CLR && s_q.wbyte[0]
        |=> s_q.clr[8])
        else $error("slew limited clear missing");
    refab_clear_a: assert property (
        commit && s_q.wlane && s_q.wr_idx == ICROR_IDX_REFAB_CLR
        |=> s_q.clr[23:16] == ($past(s_q.wbyte) & 8'h77))
        else $error("ref A/B clear byte wrong");
    refcd_clear_a: assert property (
        commit && s_q.wlane && s_q.wr_idx == ICROR_IDX_REFCD_CLR
        |=> s_q.clr[31:24] == ($past(s_q.wbyte) & 8'h77))
        else $error("ref C/D clear byte wrong");
    phase_reset_a: assert property (
        wr_phase && s_q.wbyte[2] |=> phase_offset == 16'h0000)
        else $error("phase offset not zeroed");
    phase_dec_a: assert property (
        wr_phase && s_q.wbyte[2:0] == 3'h2
        |=> phase_offset == 16'($past(phase_offset) - $past(s_q.step)))
        else $error("decrement wrong");
    phase_inc_a: assert property (
        wr_phase && s_q.wbyte[2:0] == 3'h1
        |=> phase_offset == 16'($past(phase_offset) + $past(s_q.step)))
        else $error("increment wrong");
    phase_once_a: assert property (
        wr_phase |=> ##1 $stable(phase_offset) [*2])
        else $error("phase strobe acted twice");
    force_pulse_a: assert property (
        validation_force != 4'h0 |=> validation_force == 4'h0)
        else $error("force strobe held");
    force_now_a: assert property (
        commit && s_q.wlane && s_q.wr_idx == ICROR_IDX_VAL_FORCE && s_q.wbyte[0]
        |=> validation_force[0])
        else $error("forced expiry late");
    override_hold_a: assert property (
        !(commit && s_q.wr_idx == ICROR_IDX_FAULT_OVR) |=> $stable(ref_fault_override))
        else $error("override changed without write");
    bypass_write_a: assert property (
        commit && s_q.wlane && s_q.wr_idx == ICROR_IDX_MON_BYP
        |=> ref_monitor_bypass == $past(s_q.wbyte[3:0]))
        else $error("bypass not written");
    clear_pulse_a: assert property (
        s_q.clr != 32'h0 |=> s_q.clr == 32'h0)
        else $error("clear bits held");
    zero_noop_a: assert property (
        wr_phase && s_q.wbyte[2:0] == 3'h0 |=> $stable(phase_offset))
        else $error("zero write moved offset");

    write_done_c: cover property (commit ##1 s_axi_bvalid && s_axi_bready);
    read_done_c: cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
    phase_step_c: cover property (wr_phase && s_q.wbyte[0]);

endmodule // icror_top

// *** tb/test_irq_clear_and_ref_override_regs.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Self-checking bench for the clear and override register bank
// ==========================================================================
module test_irq_clear_and_ref_override_regs import icror_pkg::*; ;
    logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0;
    logic        bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [15:0] awa = 16'h0000, ara = 16'h0000;
    logic [31:0] wd = 32'h0000_0000;
    logic [3:0]  ws = 4'h0;
    icror_evt_t  ev = '0;
    logic        awr, wrdy, bv, arr, rv, irq;
    logic [1:0]  br, rr, last_rresp, last_bresp;
    logic [31:0] rd, st, exp_st;
    logic [15:0] po;
    logic [3:0]  vf, fo, mb;
    logic [3:0]  vf_seen = 4'h0;
    int          vf_cyc = 0, failures = 0, tests_run = 0, cycles = 0;

    icror_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .evt_set(ev),
        .evt_status(st), .irq(irq), .phase_offset(po), .validation_force(vf),
        .ref_fault_override(fo), .ref_monitor_bypass(mb));

    // ======================================================================
    // Clock, watchdog and pulse monitor
    // ======================================================================
    initial forever #2 aclk = ~aclk;
    // Hang guard: whole run needs well under a few thousand cycles
    always @(posedge aclk) begin
        cycles++;
        if (vf !== 4'h0) begin
            vf_seen |= vf;
            vf_cyc++;
        end
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    // ======================================================================
    // Bus tasks and compare
    // ======================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        @(posedge aclk);
        awa <= {idx, 2'b00}; wd <= {24'h0, d}; ws <= 4'h1;
        awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        last_bresp = br;
        bry <= 1'b0;
        @(posedge aclk); // Let flag clears land before anyone looks
    endtask
    task automatic rdc(input logic [13:0] idx, input logic [7:0] exp);
        @(posedge aclk);
        ara <= {idx, 2'b00}; arv <= 1'b1; rry <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        rry <= 1'b0;
        last_rresp = rr;
        chk(rd, {24'h0, exp});
    endtask
    task automatic pulse(input logic [31:0] v);
        @(posedge aclk); ev <= icror_evt_t'(v);
        @(posedge aclk); ev <= '0;
        @(posedge aclk);
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ======================================================================
    // Test sequence
    // ======================================================================
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(ICROR_IDX_FAULT_OVR, 8'h00);
        rdc(ICROR_IDX_MON_BYP, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) wr(ICROR_IDX_EN_BASE + 14'(i), 8'hff);
        pulse(32'hffff_ffff);
        exp_st = ICROR_EVT_MASK;
        chk(st, exp_st);
        chk({31'h0, irq}, 32'h1);
        wr(ICROR_IDX_DPLL_CLR, 8'h00);
        chk(st, exp_st);
        // Walk every bit of every clear byte, one flag at a time
        for (int r = 0; r < 4; r++) for (int b = 0; b < 8; b++) begin
            wr(ICROR_IDX_DPLL_CLR + 14'(r), 8'h01 << b);
            exp_st &= ~(32'h1 << (8 * r + b));
            chk(st, exp_st);
        end
        wr(ICROR_IDX_STAT_BASE, 8'hff);
        chk(st, exp_st);
        chk({30'h0, last_bresp}, {30'h0, ICROR_RESP_OKAY});
        chk({31'h0, irq}, 32'h0);
        pulse(32'h0000_0001);
        chk(st, 32'h0000_0001);
        wr(ICROR_IDX_EN_BASE, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(ICROR_IDX_DPLL_CLR, 8'h01);
        chk(st, 32'h0);
        // Event still present while its clear lands; recheck after clearing
        ev <= icror_evt_t'(32'h0000_0008);
        wr(ICROR_IDX_DPLL_CLR, 8'h08);
        chk(st, 32'h0000_0008);
        ev <= '0;
        wr(ICROR_IDX_DPLL_CLR, 8'h08);
        chk(st, 32'h0);
        $display("test event clears done");
        wr(ICROR_IDX_STEP_LO, 8'h34);
        wr(ICROR_IDX_STEP_HI, 8'h12);
        wr(ICROR_IDX_PHASE_CTL, 8'h01);
        wr(ICROR_IDX_PHASE_CTL, 8'h01);
        chk({16'h0, po}, 32'h2468);
        wr(ICROR_IDX_PHASE_CTL, 8'h02);
        chk({16'h0, po}, 32'h1234);
        wr(ICROR_IDX_PHASE_CTL, 8'h04);
        chk({16'h0, po}, 32'h0);
        wr(ICROR_IDX_PHASE_CTL, 8'h02);
        rdc(ICROR_IDX_ACC_HI, 8'hed);
        wr(ICROR_IDX_PHASE_CTL, 8'h07);
        chk({16'h0, po}, 32'h0);
        rdc(ICROR_IDX_PHASE_CTL, 8'h00);
        $display("test phase offset done");
        for (int n = 0; n < 4; n++) begin
            vf_seen = 4'h0;
            vf_cyc = 0;
            wr(ICROR_IDX_VAL_FORCE, 8'h01 << n);
            chk({28'h0, vf_seen}, 32'h1 << n);
            chk(32'(vf_cyc), 32'h1);
        end
        $display("test validation force done");
        wr(ICROR_IDX_FAULT_OVR, 8'hf5);
        chk({28'h0, fo}, 32'h5);
        rdc(ICROR_IDX_FAULT_OVR, 8'h05);
        wr(ICROR_IDX_MON_BYP, 8'h0a);
        chk({28'h0, mb}, 32'ha);
        rdc(ICROR_IDX_MON_BYP, 8'h0a);
        rdc(14'h0100, 8'h00);
        chk({30'h0, last_rresp}, {30'h0, ICROR_RESP_SLVERR});
        wr(14'h0100, 8'hff);
        chk({30'h0, last_bresp}, {30'h0, ICROR_RESP_SLVERR});
        $display("test override and unmapped done");
        report_and_stop();
    end
endmodule // test_irq_clear_and_ref_override_regs
